// >>> hw/mad_defines.svh
/*
 Constants of the motion activity detector: register indices, field
 positions, field encodings and reset values.
 Assumes register byte address = 4 * index on a 32-bit AHB-Lite bus.
*/
`ifndef MAD_DEFINES_SVH
`define MAD_DEFINES_SVH

`define MAD_AXES              3
`define MAD_SW                14
`define MAD_TW                16
`define MAD_IW                8

`define MAD_IDX_STATUS        8'h0B
`define MAD_IDX_THR_ACT       8'h20
`define MAD_IDX_TIM_ACT       8'h22
`define MAD_IDX_THR_INACT     8'h23
`define MAD_IDX_TIM_INACT     8'h25
`define MAD_IDX_ACT_INACT_CTL 8'h27
`define MAD_IDX_INT_MAP       8'h2A
`define MAD_IDX_POWER_CTL     8'h2D

`define MAD_EN_OFF            2'h0
`define MAD_EN_ABS            2'h1
`define MAD_EN_REF            2'h3

`define MAD_PWR_STANDBY       2'h0
`define MAD_PWR_MEASURE       2'h2
`define MAD_PWR_WAKEUP        2'h3

`define MAD_CTL_ACT_EN_LSB    0
`define MAD_CTL_STILL_EN_LSB  2
`define MAD_CTL_LINK_BIT      4
`define MAD_CTL_AXIS_LSB      5

`define MAD_STAT_ACT_BIT      4
`define MAD_STAT_INACT_BIT    5
`define MAD_STAT_AWAKE_BIT    6

`define MAD_RST_THR           14'h0000
`define MAD_RST_TIM           16'h0000
`define MAD_RST_AXIS          3'h7

`endif

// >>> hw/mad_pkg.sv
/*
 Types of the motion activity detector.
 Assumes mad_defines.svh for the axis, sample, timer and index widths.
*/
`include "mad_defines.svh"

package mad_pkg;

    typedef enum logic {
        MAD_SRCH_ACT   = 1'b0,
        MAD_SRCH_INACT = 1'b1
    } mad_srch_t;

    typedef logic [`MAD_AXES-1:0][`MAD_SW-1:0] mad_axes_t;

    typedef struct packed {
        logic      valid;
        mad_axes_t axis;
    } mad_sample_t;

    typedef struct packed {
        logic [`MAD_SW-1:0]   thr_act;
        logic [`MAD_TW-1:0]   tim_act;
        logic [`MAD_SW-1:0]   thr_inact;
        logic [`MAD_TW-1:0]   tim_inact;
        logic [1:0]           act_en;
        logic [1:0]           stillness_detect_enable_select;
        logic                 link;
        logic [`MAD_AXES-1:0] axis_en;
        logic [1:0]           int_map;
        logic [1:0]           pwr;
        logic                 act_flag;
        logic                 inact_flag;
        logic                 awake;
        logic [`MAD_TW-1:0]   act_cnt;
        logic [`MAD_TW-1:0]   inact_cnt;
        mad_axes_t            act_ref;
        mad_axes_t            inact_ref;
        logic                 ref_ok;
        logic                 running;
        mad_srch_t            srch;
        logic                 wr_pend;
        logic [`MAD_IW-1:0]   wr_idx;
        logic [31:0]          rdata;
        logic                 irq;
    } mad_state_t;

endpackage

// >>> hw/mad_axis_cmp.sv
/*
 One axis of threshold comparison for activity and stillness.
 Assumes signed two's complement samples and references.
*/
`timescale 1ns/1ps
`include "mad_defines.svh"

module mad_axis_cmp (
    input  wire logic [`MAD_SW-1:0] sample,
    input  wire logic [`MAD_SW-1:0] act_ref,
    input  wire logic [`MAD_SW-1:0] inact_ref,
    input  wire logic               use_act_ref,
    input  wire logic               use_inact_ref,
    input  wire logic [`MAD_SW-1:0] thr_act,
    input  wire logic [`MAD_SW-1:0] thr_inact,
    output logic                    over_act,
    output logic                    under_inact
);
    logic signed [`MAD_SW:0] d_act;
    logic signed [`MAD_SW:0] d_inact;
    logic        [`MAD_SW:0] m_act;
    logic        [`MAD_SW:0] m_inact;

    // One bit of extra width keeps the difference from wrapping
    always_comb begin
        d_act   = use_act_ref ? ($signed({sample[`MAD_SW-1], sample})
                                 - $signed({act_ref[`MAD_SW-1], act_ref}))
                              : $signed({sample[`MAD_SW-1], sample});
        d_inact = use_inact_ref ? ($signed({sample[`MAD_SW-1], sample})
                                   - $signed({inact_ref[`MAD_SW-1], inact_ref}))
                                : $signed({sample[`MAD_SW-1], sample});
        m_act   = d_act[`MAD_SW] ? (`MAD_SW+1)'(-d_act) : d_act;
        m_inact = d_inact[`MAD_SW] ? (`MAD_SW+1)'(-d_inact) : d_inact;
        over_act    = m_act > {1'b0, thr_act};
        under_inact = m_inact < {1'b0, thr_inact};
    end
endmodule // mad_axis_cmp

// >>> hw/mad_top.sv
/*
 Motion activity detector: activity and stillness qualification on the
 sample stream, references, link search, status and AHB-Lite registers.
 Assumes smp.valid is a one-cycle pulse per output-data-rate sample and
 that smp.axis is stable while it is high; zero-wait AHB-Lite slave.
*/
// Function
// - Activity when any enabled axis exceeds threshold
// - Absolute activity compares sample to threshold
// - Referenced per function when its own enable field equals 11
// - Referenced activity uses deviation from reference
// - Activity reference captured at start, link, repeat
// - First measurement sample uses absolute thresholds
// - Activity timer from one sample upward
// - Wake-up mode decides activity on one sample
// - Stillness needs every enabled axis below threshold
// - Absolute stillness counts consecutive samples below
// - Referenced stillness stays within reference band
// - Stillness reference at start and each stillness event
// - Early motion keeps old stillness reference
// - Stillness timer up to 65535 samples
// - Events set status flags and optional interrupt
// - Detection in measurement and wake-up modes
// - Link mode alternates activity and stillness search
// - Awake starts 1, follows serviced events
`timescale 1ns/1ps
`include "mad_defines.svh"

module mad_top (
    input  wire logic               ref_clk,
    input  wire logic               rst_n,
    input  wire mad_pkg::mad_sample_t smp,
    input  wire logic               hsel,
    input  wire logic [31:0]        haddr,
    input  wire logic [1:0]         htrans,
    input  wire logic               hwrite,
    input  wire logic [2:0]         hsize,
    input  wire logic [31:0]        hwdata,
    input  wire logic               hready,
    output logic                    hreadyout,
    output logic                    hresp,
    output logic [31:0]             hrdata,
    output logic                    event_irq,
    output logic                    awake
);
    import mad_pkg::*;

    mad_state_t           q;
    mad_state_t           s;
    logic [`MAD_AXES-1:0] over;
    logic [`MAD_AXES-1:0] under;
    logic                 referenced;
    logic                 use_ref;
    logic                 run;
    logic                 wake;
    logic                 act_on;
    logic                 inact_on;
    logic                 any_over;
    logic                 all_under;
    logic                 take;
    logic                 addr_ph;
    logic                 rd_status;
    logic                 act_evt;
    logic                 inact_evt;
    logic [`MAD_TW:0]     act_nxt;
    logic [`MAD_TW:0]     inact_nxt;
    logic [`MAD_IW-1:0]   idx;
    logic [31:0]          rmux;

    assign referenced = (q.act_en == `MAD_EN_REF)
                     || (q.stillness_detect_enable_select == `MAD_EN_REF);
    assign use_ref    = referenced && q.ref_ok;
    assign run        = (q.pwr == `MAD_PWR_MEASURE) || (q.pwr == `MAD_PWR_WAKEUP);
    assign wake       = q.pwr == `MAD_PWR_WAKEUP;
    assign act_on     = (q.act_en != `MAD_EN_OFF) && (!q.link || q.srch == MAD_SRCH_ACT);
    assign inact_on   = (q.stillness_detect_enable_select != `MAD_EN_OFF)
                     && (!q.link || q.srch == MAD_SRCH_INACT);
    assign any_over   = |(over & q.axis_en);
    assign all_under  = (q.axis_en != '0) && (&(under | ~q.axis_en));
    assign take       = smp.valid && run && q.running;
    assign act_nxt    = {1'b0, q.act_cnt} + (`MAD_TW+1)'(1);
    assign inact_nxt  = {1'b0, q.inact_cnt} + (`MAD_TW+1)'(1);
    // A programmed time of zero or one both mean a single sample
    assign act_evt    = take && act_on && any_over
                     && (wake || act_nxt >= {1'b0, q.tim_act});
    assign inact_evt  = take && inact_on && all_under
                     && (inact_nxt >= {1'b0, q.tim_inact});
    assign addr_ph    = hsel && htrans[1] && hready;
    assign idx        = haddr[`MAD_IW+1:2];
    assign rd_status  = addr_ph && !hwrite && (idx == `MAD_IDX_STATUS);

    genvar g;
    generate
        for (g = 0; g < `MAD_AXES; g++) begin : g_axis
            mad_axis_cmp u_cmp (
                .sample        (smp.axis[g]),
                .act_ref       (q.act_ref[g]),
                .inact_ref     (q.inact_ref[g]),
                .use_act_ref   (use_ref && q.act_en == `MAD_EN_REF),
                .use_inact_ref (use_ref && q.stillness_detect_enable_select == `MAD_EN_REF),
                .thr_act       (q.thr_act),
                .thr_inact     (q.thr_inact),
                .over_act      (over[g]),
                .under_inact   (under[g])
            );
        end
    endgenerate

    always_comb begin
        rmux = 32'h0000_0000;
        unique case (idx)
            `MAD_IDX_STATUS:        rmux[`MAD_STAT_AWAKE_BIT:`MAD_STAT_ACT_BIT] =
                                        {q.awake, q.inact_flag, q.act_flag};
            `MAD_IDX_THR_ACT:       rmux[`MAD_SW-1:0] = q.thr_act;
            `MAD_IDX_TIM_ACT:       rmux[`MAD_TW-1:0] = q.tim_act;
            `MAD_IDX_THR_INACT:     rmux[`MAD_SW-1:0] = q.thr_inact;
            `MAD_IDX_TIM_INACT:     rmux[`MAD_TW-1:0] = q.tim_inact;
            `MAD_IDX_ACT_INACT_CTL: rmux[`MAD_CTL_AXIS_LSB+`MAD_AXES-1:0] =
                                        {q.axis_en, q.link,
                                         q.stillness_detect_enable_select, q.act_en};
            `MAD_IDX_INT_MAP:       rmux[1:0] = q.int_map;
            `MAD_IDX_POWER_CTL:     rmux[1:0] = q.pwr;
            default:                rmux = 32'h0000_0000;
        endcase
    end

    always_comb begin
        s = q;
        // Register writes land in the data phase
        if (q.wr_pend) begin
            unique case (q.wr_idx)
                `MAD_IDX_THR_ACT:   s.thr_act   = hwdata[`MAD_SW-1:0];
                `MAD_IDX_TIM_ACT:   s.tim_act   = hwdata[`MAD_TW-1:0];
                `MAD_IDX_THR_INACT: s.thr_inact = hwdata[`MAD_SW-1:0];
                `MAD_IDX_TIM_INACT: s.tim_inact = hwdata[`MAD_TW-1:0];
                `MAD_IDX_ACT_INACT_CTL: begin
                    s.act_en  = hwdata[`MAD_CTL_ACT_EN_LSB+:2];
                    s.stillness_detect_enable_select = hwdata[`MAD_CTL_STILL_EN_LSB+:2];
                    s.link    = hwdata[`MAD_CTL_LINK_BIT];
                    s.axis_en = hwdata[`MAD_CTL_AXIS_LSB+:`MAD_AXES];
                end
                `MAD_IDX_INT_MAP:   s.int_map = hwdata[1:0];
                `MAD_IDX_POWER_CTL: s.pwr     = hwdata[1:0];
                default: ;
            endcase
        end
        s.wr_pend = 1'b0;
        if (addr_ph) begin
            s.wr_pend = hwrite;
            s.wr_idx  = idx;
            if (!hwrite) begin
                s.rdata = rmux;
            end
        end
        // Reading status services the flags; awake follows the serviced event
        if (rd_status) begin
            if (q.inact_flag) begin
                s.awake = 1'b0;
            end
            if (q.act_flag) begin
                s.awake = 1'b1;
            end
            s.act_flag   = 1'b0;
            s.inact_flag = 1'b0;
        end
        // Entering a running mode restarts search with no reference yet
        s.running = run;
        if (run && !q.running) begin
            s.ref_ok    = 1'b0;
            s.act_cnt   = '0;
            s.inact_cnt = '0;
            s.srch      = MAD_SRCH_ACT;
        end
        if (take) begin
            if (!q.ref_ok) begin
                s.act_ref   = smp.axis;
                s.inact_ref = smp.axis;
                s.ref_ok    = 1'b1;
            end
            s.act_cnt   = (act_on && any_over) ? act_nxt[`MAD_TW-1:0] : '0;
            s.inact_cnt = (inact_on && all_under) ? inact_nxt[`MAD_TW-1:0] : '0;
            // Set wins over a status read in the same cycle
            if (act_evt) begin
                s.act_flag = 1'b1;
                s.act_cnt  = '0;
                if (q.link) begin
                    s.srch      = MAD_SRCH_INACT;
                    s.inact_cnt = '0;
                end else begin
                    s.act_ref = smp.axis;
                end
            end
            if (inact_evt) begin
                s.inact_flag = 1'b1;
                s.inact_cnt  = '0;
                s.inact_ref  = smp.axis;
                if (q.link) begin
                    s.srch    = MAD_SRCH_ACT;
                    s.act_cnt = '0;
                    s.act_ref = smp.axis;
                end
            end
        end
        s.irq = |({s.inact_flag, s.act_flag} & s.int_map);
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            q           <= '0;
            q.thr_act   <= `MAD_RST_THR;
            q.tim_act   <= `MAD_RST_TIM;
            q.thr_inact <= `MAD_RST_THR;
            q.tim_inact <= `MAD_RST_TIM;
            q.axis_en   <= `MAD_RST_AXIS;
            q.pwr       <= `MAD_PWR_STANDBY;
            q.awake     <= 1'b1;
            q.srch      <= MAD_SRCH_ACT;
        end else begin
            q <= s;
        end
    end

    // Zero-wait slave; unmapped reads give zero, unmapped writes are dropped
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = q.rdata;
    assign event_irq = q.irq;
    assign awake     = q.awake;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    sequence s_wake_hit;
        take && wake && act_on && any_over;
    endsequence

    sequence s_stat_read_act;
        rd_status && q.act_flag && !act_evt;
    endsequence

    sequence s_still_serviced;
        rd_status && q.inact_flag && !q.act_flag;
    endsequence

    a_wake_single: assert property (s_wake_hit |=> q.act_flag && q.act_cnt == '0)
        else $error("wake-up sample over threshold did not flag activity");
    a_act_cause: assert property ($rose(q.act_flag) |-> $past(any_over && take))
        else $error("activity flagged without an enabled axis over threshold");
    a_still_cause: assert property ($rose(q.inact_flag) |-> $past(all_under && take))
        else $error("stillness flagged without all enabled axes under threshold");
    a_first_ref: assert property (take && !q.ref_ok |=> q.ref_ok
                                  && q.inact_ref == $past(smp.axis))
        else $error("first running sample did not establish references");
    a_timer_restart: assert property (take && act_on && !any_over |=> q.act_cnt == '0)
        else $error("activity timer kept counting after a failing sample");
    a_link_swap: assert property (act_evt && q.link && !inact_evt
                                  |=> q.srch == MAD_SRCH_INACT)
        else $error("link mode did not switch to stillness search");
    a_flag_clear: assert property (s_stat_read_act |=> !q.act_flag && q.awake)
        else $error("status read did not service the activity flag");
    a_awake_drop: assert property (s_still_serviced |=> !q.awake)
        else $error("awake stayed high after serviced stillness");
    a_still_ref_hold: assert property (q.ref_ok && !$past(inact_evt) && $stable(q.ref_ok)
                                       |-> $stable(q.inact_ref))
        else $error("stillness reference moved without a stillness event");
    a_still_count: assert property (take && inact_on && all_under && !inact_evt
                                    |=> q.inact_cnt == $past(q.inact_cnt) + 16'h0001)
        else $error("stillness timer did not advance on a qualifying sample");

    // Flags, awake and references move only on the events and reads that own them
    sequence s_link_still_hit;
        inact_evt && q.link;
    endsequence

    a_standby_quiet: assert property (!run |=> !$rose(q.act_flag)
                                      && !$rose(q.inact_flag))
        else $error("event flagged while not in a running mode");
    a_entry_drops_ref: assert property (run && !q.running |=> !q.ref_ok)
        else $error("entering a running mode kept an old reference");
    a_timer_wait: assert property (take && !wake && act_on && any_over
                                   && act_nxt < {1'b0, q.tim_act} |=> !$rose(q.act_flag))
        else $error("activity flagged before the activity time ran out");
    a_still_restart: assert property (take && inact_on && !all_under
                                      |=> q.inact_cnt == '0)
        else $error("stillness timer kept counting after a failing sample");
    a_no_axis_still: assert property (q.axis_en == '0 |-> !inact_evt)
        else $error("stillness detected with no axis enabled");
    a_act_reref: assert property (act_evt && !q.link
                                  |=> q.act_ref == $past(smp.axis))
        else $error("repeated activity search kept the old reference");
    a_still_reref: assert property (inact_evt |=> q.inact_ref == $past(smp.axis))
        else $error("stillness event did not renew the stillness reference");
    a_link_return: assert property (s_link_still_hit
                                    |=> q.srch == MAD_SRCH_ACT
                                    && q.act_ref == $past(smp.axis))
        else $error("link mode did not return to activity search with a new reference");
    a_act_flag_hold: assert property (q.act_flag && !rd_status |=> q.act_flag)
        else $error("activity flag dropped without a status read");
    a_still_flag_hold: assert property (q.inact_flag && !rd_status |=> q.inact_flag)
        else $error("stillness flag dropped without a status read");
    a_awake_hold: assert property (!rd_status |=> $stable(q.awake))
        else $error("awake changed without a status read");

endmodule // mad_top

// >>> dv/mad_host.sv
/*
 Host processor model: AHB-Lite master that programs the detector and
 services its status. Assumes hready is the slave's hreadyout.
*/
`timescale 1ns/1ps
`include "mad_defines.svh"

module mad_host (
    input  wire logic        ref_clk,
    output logic             hsel,
    output logic [31:0]      haddr,
    output logic [1:0]       htrans,
    output logic             hwrite,
    output logic [2:0]       hsize,
    output logic [31:0]      hwdata,
    input  wire logic        hready,
    input  wire logic [31:0] hrdata
);
    initial begin
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
    end

    // No fixed latency assumed: both phases wait for hready
    task automatic xfer(input logic wr, input logic [7:0] idx, input logic [31:0] wd,
                        output logic [31:0] rd);
        @(posedge ref_clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {22'h0, idx, 2'h0};
        hwrite <= wr;
        do @(posedge ref_clk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge ref_clk); while (hready !== 1'b1);
        rd = hrdata;
    endtask

    task automatic wr(input logic [7:0] idx, input logic [15:0] wd);
        logic [31:0] d;
        xfer(1'b1, idx, {16'h0, wd}, d);
    endtask

    task automatic rd(input logic [7:0] idx, output logic [31:0] d);
        xfer(1'b0, idx, 32'h0, d);
    endtask

    // Sub-reference stillness: start with a wide band, narrow it once running
    task automatic start_ref_still(input logic [15:0] hi, input logic [15:0] lo);
        wr(`MAD_IDX_THR_INACT, hi);
        wr(`MAD_IDX_POWER_CTL, {14'h0, `MAD_PWR_MEASURE});
        wr(`MAD_IDX_THR_INACT, lo);
    endtask
endmodule // mad_host

// >>> dv/tb_top.sv
/*
 Self-checking bench of the motion activity detector.
 Assumes mad_host as bus master and a zero-or-more wait slave.
*/
`timescale 1ns/1ps
`include "mad_defines.svh"

module tb_top;
    import mad_pkg::*;
    logic ref_clk;
    logic rst_n;
    mad_sample_t smp;
    logic hsel, hwrite, hreadyout, hresp, event_irq, awake;
    logic [31:0] haddr, hwdata, hrdata, s;
    logic [1:0] htrans;
    logic [2:0] hsize;
    int errors;
    int checks_done;

    mad_top u_dut (.ref_clk(ref_clk), .rst_n(rst_n), .smp(smp), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .event_irq(event_irq), .awake(awake));
    mad_host u_host (.ref_clk(ref_clk), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata));

    always #5 ref_clk = ~ref_clk;

    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t: word %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t: bit %b expected %b", $time, got, exp);
        end
    endtask

    // Samples toggle to inverse data outside valid so stale values never help
    task automatic send(input logic [13:0] x, input logic [13:0] y, input logic [13:0] z);
        @(posedge ref_clk);
        smp.valid <= 1'b1;
        smp.axis <= {z, y, x};
        @(posedge ref_clk);
        smp.valid <= 1'b0;
        smp.axis <= ~{z, y, x};
        #1;
    endtask

    task automatic flags(output logic [31:0] f);
        u_host.rd(`MAD_IDX_STATUS, f);
        f = f & 32'h30;
    endtask

    // Configure only in standby, then clear old flags
    task automatic setup(input logic [15:0] ctl, input logic [15:0] tha,
                         input logic [15:0] ta, input logic [15:0] thi, input logic [15:0] ti);
        logic [31:0] d;
        u_host.wr(`MAD_IDX_POWER_CTL, {14'h0, `MAD_PWR_STANDBY});
        u_host.wr(`MAD_IDX_THR_ACT, tha);
        u_host.wr(`MAD_IDX_TIM_ACT, ta);
        u_host.wr(`MAD_IDX_THR_INACT, thi);
        u_host.wr(`MAD_IDX_TIM_INACT, ti);
        u_host.wr(`MAD_IDX_ACT_INACT_CTL, ctl);
        u_host.wr(`MAD_IDX_INT_MAP, 16'h0003);
        u_host.rd(`MAD_IDX_STATUS, d);
    endtask

    task automatic go(input logic [1:0] pwr);
        u_host.wr(`MAD_IDX_POWER_CTL, {14'h0, pwr});
    endtask

    task automatic t_reset;
        chk_bit(awake, 1'b1);
        chk_bit(event_irq, 1'b0);
        chk_bit(hresp, 1'b0);
        chk_bit(hreadyout, 1'b1);
        u_host.rd(`MAD_IDX_STATUS, s);
        chk_word(s & 32'h70, 32'h40);
        u_host.rd(8'h01, s);
        chk_word(s, 32'h0);
        u_host.wr(`MAD_IDX_TIM_INACT, 16'hFFFF);
        u_host.rd(`MAD_IDX_TIM_INACT, s);
        chk_word(s, 32'h0000FFFF);
    endtask

    task automatic t_abs_act;
        setup(16'h0021, 16'h0064, 16'h0003, 16'h0000, 16'h0000);
        go(`MAD_PWR_MEASURE);
        repeat (4) send(14'h0000, 14'h0800, 14'h0800);
        chk_bit(event_irq, 1'b0);
        send(14'h00C8, 14'h0, 14'h0);
        send(14'h0032, 14'h0, 14'h0);
        send(14'h3F38, 14'h0, 14'h0);
        send(14'h00C8, 14'h0, 14'h0);
        chk_bit(event_irq, 1'b0);
        send(14'h00C8, 14'h0, 14'h0);
        chk_bit(event_irq, 1'b1);
        flags(s);
        chk_word(s, 32'h10);
        flags(s);
        chk_word(s, 32'h0);
    endtask

    task automatic t_one_sample;
        setup(16'h00E1, 16'h0064, 16'h0000, 16'h0000, 16'h0000);
        go(`MAD_PWR_MEASURE);
        send(14'h00C8, 14'h0, 14'h0);
        chk_bit(event_irq, 1'b1);
        setup(16'h00E1, 16'h0064, 16'h0005, 16'h0000, 16'h0000);
        go(`MAD_PWR_WAKEUP);
        send(14'h0, 14'h0, 14'h00C8);
        chk_bit(event_irq, 1'b1);
    endtask

    task automatic t_abs_still;
        setup(16'h00E4, 16'h0000, 16'h0000, 16'h0064, 16'h0004);
        go(`MAD_PWR_MEASURE);
        repeat (3) send(14'h000A, 14'h3FE2, 14'h001E);
        send(14'h000A, 14'h0014, 14'h012C);
        chk_bit(event_irq, 1'b0);
        repeat (3) send(14'h000A, 14'h0014, 14'h001E);
        chk_bit(event_irq, 1'b0);
        send(14'h000A, 14'h0014, 14'h001E);
        chk_bit(event_irq, 1'b1);
        flags(s);
        chk_word(s, 32'h20);
        chk_bit(awake, 1'b0);
    endtask

    task automatic t_ref_act;
        setup(16'h00E3, 16'h0064, 16'h0001, 16'h0000, 16'h0000);
        go(`MAD_PWR_MEASURE);
        send(14'h03E8, 14'h0, 14'h0);
        chk_bit(event_irq, 1'b1);
        flags(s);
        chk_bit(awake, 1'b1);
        send(14'h041A, 14'h0, 14'h0);
        chk_bit(event_irq, 1'b0);
        send(14'h047E, 14'h0, 14'h0);
        chk_bit(event_irq, 1'b1);
        flags(s);
        send(14'h04B0, 14'h0, 14'h0);
        send(14'h04D8, 14'h0, 14'h0);
        chk_bit(event_irq, 1'b0);
    endtask

    task automatic t_ref_still;
        setup(16'h00EC, 16'h0000, 16'h0000, 16'h0000, 16'h0003);
        u_host.start_ref_still(16'h1FFF, 16'h0064);
        send(14'h03E8, 14'h0, 14'h0);
        send(14'h03FC, 14'h0, 14'h0);
        send(14'h05DC, 14'h0, 14'h0);
        send(14'h03FC, 14'h0, 14'h0);
        send(14'h0406, 14'h0, 14'h0);
        chk_bit(event_irq, 1'b0);
        send(14'h03F2, 14'h0, 14'h0);
        chk_bit(event_irq, 1'b1);
        flags(s);
        repeat (4) send(14'h044C, 14'h0, 14'h0);
        chk_bit(event_irq, 1'b1);
    endtask

    task automatic t_link;
        setup(16'h00F5, 16'h0064, 16'h0001, 16'h0064, 16'h0001);
        u_host.rd(`MAD_IDX_ACT_INACT_CTL, s);
        chk_word(s, 32'h000000F5);
        go(`MAD_PWR_MEASURE);
        send(14'h0, 14'h0, 14'h0);
        chk_bit(event_irq, 1'b0);
        send(14'h01F4, 14'h0, 14'h0);
        flags(s);
        chk_word(s, 32'h10);
        send(14'h01F4, 14'h0, 14'h0);
        chk_bit(event_irq, 1'b0);
        send(14'h0, 14'h0, 14'h0);
        flags(s);
        chk_word(s, 32'h20);
        u_host.wr(`MAD_IDX_INT_MAP, 16'h0002);
        send(14'h01F4, 14'h0, 14'h0);
        chk_bit(event_irq, 1'b0);
        flags(s);
        chk_word(s, 32'h10);
    endtask

    task automatic summarize;
        $display("errors=%0d checks_done=%0d", errors, checks_done);
        if (errors == 0 && checks_done > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    initial begin
        ref_clk = 1'b0;
        rst_n = 1'b0;
        smp = '0;
        errors = 0;
        checks_done = 0;
        repeat (20) @(posedge ref_clk);
        rst_n <= 1'b1;
        t_reset();
        t_abs_act();
        t_one_sample();
        t_abs_still();
        t_ref_act();
        t_ref_still();
        t_link();
        summarize();
    end

    // Whole run is a few hundred cycles; this leaves wide margin
    initial begin
        #200us;
        errors++;
        summarize();
    end
endmodule // tb_top
